// *** core/vatu_pkg.sv ***
// Purpose: Shared constants and types for the address translation unit
// Assumes: 32-bit virtual and physical addresses, word-wide walk reads
// Notes:   Register numbers are the coprocessor register selectors
`default_nettype none
package vatu_pkg;
   // ----------------------------------------------------------------
   // Register selectors
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h1;
   localparam logic [3:0] REG_TBASE = 4'h2;
   localparam logic [3:0] REG_DAC = 4'h3;
   localparam logic [3:0] REG_FSTAT = 4'h5;
   localparam logic [3:0] REG_FVA = 4'h6;
   localparam logic [3:0] REG_TLBOP = 4'h8;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] TBASE_RST = 32'h0000_0000;
   localparam logic [31:0] DAC_RST = 32'h0000_0000;
   localparam logic [31:0] FSTAT_RST = 32'h0000_0000;
   localparam logic [31:0] FVA_RST = 32'h0000_0000;
   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTL_EN = 0;
   localparam int CTL_S = 8;
   localparam int CTL_R = 9;
   localparam int FSTAT_DOM_LSB = 4;
   // ----------------------------------------------------------------
   // Cache geometry and descriptor codes
   // ----------------------------------------------------------------
   localparam int TLB_DEPTH = 64;
   localparam int TLB_AW = 6;
   localparam logic [1:0] L1_INVALID = 2'h0;
   localparam logic [1:0] L1_PAGE = 2'h1;
   localparam logic [1:0] L1_SECT = 2'h2;
   localparam logic [1:0] L2_INVALID = 2'h0;
   localparam logic [1:0] L2_LARGE = 2'h1;
   localparam logic [1:0] L2_SMALL = 2'h2;
   localparam logic [1:0] DA_NONE = 2'h0;
   localparam logic [1:0] DA_CLIENT = 2'h1;
   localparam logic [1:0] DA_RSVD = 2'h2;
   localparam logic [3:0] FS_TRANS_SECT = 4'h5;
   localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
   localparam logic [3:0] FS_DOM_SECT = 4'h9;
   localparam logic [3:0] FS_DOM_PAGE = 4'hB;
   localparam logic [3:0] FS_PERM_SECT = 4'hD;
   localparam logic [3:0] FS_PERM_PAGE = 4'hF;
   typedef enum logic [1:0] {
      VATU_SZ_SECT = 2'h0,
      VATU_SZ_LARGE = 2'h1,
      VATU_SZ_SMALL = 2'h2
   } vatu_size_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_LOOK = 3'h1,
      ST_L1 = 3'h3,
      ST_L2 = 3'h2,
      ST_FILL = 3'h6
   } vatu_state_t;
endpackage
`default_nettype wire

// *** core/vatu_tlb.sv ***
// Purpose: 64-entry fully associative translation cache
// Assumes: At most one entry matches a given address
// Notes:   Victim pointer steps once per fill, never skips
`timescale 1ns/1ns
`default_nettype none
module vatu_tlb
   import vatu_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   vatu_tlb_if.tlb t
);
   logic [TLB_DEPTH-1:0] val_q;
   logic [TLB_DEPTH-1:0] val_d;
   logic [19:0] tag_q [TLB_DEPTH];
   vatu_size_t sz_q [TLB_DEPTH];
   logic [19:0] pb_q [TLB_DEPTH];
   logic [3:0] dom_q [TLB_DEPTH];
   logic [7:0] ap_q [TLB_DEPTH];
   logic [TLB_AW-1:0] rr_q;
   logic [TLB_DEPTH-1:0] hit_v;
   logic [TLB_DEPTH-1:0] inv_v;
   logic [TLB_AW-1:0] hit_idx;
   logic [1:0] sub;
   vatu_size_t sel_sz;
   logic [19:0] sel_pb;
   logic [7:0] sel_ap;

   // Compare masks by mapping size
   function automatic logic va_match(input logic [19:0] tag,
      input vatu_size_t sz, input logic [31:0] va);
      case (sz)
         VATU_SZ_SECT: va_match = tag[19:8] == va[31:20];
         VATU_SZ_LARGE: va_match = tag[19:4] == va[31:16];
         default: va_match = tag == va[31:12];
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Match and invalidate vectors
   // ----------------------------------------------------------------
   for (genvar i = 0; i < TLB_DEPTH; i++) begin : g_ent
      assign hit_v[i] = val_q[i] && va_match(tag_q[i], sz_q[i], t.lk_va);
      assign inv_v[i] = t.inv_all || (t.inv_one &&
         va_match(tag_q[i], sz_q[i], t.inv_va));
   end

   // Encode the single hitting entry
   always_comb begin
      hit_idx = '0;
      for (int k = 0; k < TLB_DEPTH; k++) begin
         if (hit_v[k]) begin
            hit_idx = k[TLB_AW-1:0];
         end
      end
   end

   // Read out the hitting entry; section AP is stored four times
   assign sel_sz = sz_q[hit_idx];
   assign sel_pb = pb_q[hit_idx];
   assign sel_ap = ap_q[hit_idx];
   assign sub = (sel_sz == VATU_SZ_SMALL) ? t.lk_va[11:10] :
      t.lk_va[15:14];
   assign t.hit = |hit_v;
   assign t.hit_size = sel_sz;
   assign t.hit_dom = dom_q[hit_idx];
   assign t.hit_ap = sel_ap[{sub, 1'b0} +: 2];
   assign t.hit_pa = (sel_sz == VATU_SZ_SECT) ?
      {sel_pb[19:8], t.lk_va[19:0]} :
      (sel_sz == VATU_SZ_LARGE) ? {sel_pb[19:4], t.lk_va[15:0]} :
      {sel_pb, t.lk_va[11:0]};

   // Invalidate first, so a fill in the same cycle still lands
   always_comb begin
      val_d = val_q & ~inv_v;
      if (t.fill) begin
         val_d[rr_q] = 1'b1;
      end
   end

   // Valid bits and round-robin victim pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         val_q <= '0;
         rr_q <= '0;
      end else begin
         val_q <= val_d;
         if (t.fill) begin
            rr_q <= rr_q + 1'b1;
         end
      end
   end

   // Entry contents need no reset; valid bits guard them
   always_ff @(posedge clk) begin
      if (t.fill) begin
         tag_q[rr_q] <= t.fill_tag;
         sz_q[rr_q] <= t.fill_size;
         pb_q[rr_q] <= t.fill_pbase;
         dom_q[rr_q] <= t.fill_dom;
         ap_q[rr_q] <= t.fill_ap;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   chk_rr_step: assert property (t.fill |=>
      rr_q == $past(rr_q) + 1'b1) else $error("victim pointer skipped");
   chk_inv_all: assert property (t.inv_all && !t.fill |=>
      val_q == '0) else $error("flush left valid entries");
   chk_fill_val: assert property (t.fill |=>
      val_q[$past(rr_q)]) else $error("filled entry not valid");
endmodule
`default_nettype wire

// *** core/vatu_tlb_if.sv ***
// Purpose: Lookup, fill and invalidate path between control and cache
// Assumes: Lookup answers combinationally in the same cycle
// Notes:   Fill tag is always virtual bits 31..12; size masks the compare
`timescale 1ns/1ns
`default_nettype none
interface vatu_tlb_if;
   import vatu_pkg::*;
   logic [31:0] lk_va;
   logic hit;
   logic [31:0] hit_pa;
   logic [3:0] hit_dom;
   logic [1:0] hit_ap;
   vatu_size_t hit_size;
   logic fill;
   logic [19:0] fill_tag;
   vatu_size_t fill_size;
   logic [19:0] fill_pbase;
   logic [3:0] fill_dom;
   logic [7:0] fill_ap;
   logic inv_all;
   logic inv_one;
   logic [31:0] inv_va;
   modport ctl (output lk_va, fill, fill_tag, fill_size, fill_pbase,
      fill_dom, fill_ap, inv_all, inv_one, inv_va,
      input hit, hit_pa, hit_dom, hit_ap, hit_size);
   modport tlb (input lk_va, fill, fill_tag, fill_size, fill_pbase,
      fill_dom, fill_ap, inv_all, inv_one, inv_va,
      output hit, hit_pa, hit_dom, hit_ap, hit_size);
endinterface
`default_nettype wire

// *** core/vatu_top.sv ***
// Purpose: Virtual address translation unit with table walker
// Assumes: CPU holds VA_REQ for one cycle per access, then waits DONE
// Notes:   Walk memory answers with WALK_ACK and WALK_RDATA together
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Translation off, as after reset, passes virtual address straight out
// - Section entries map one whole 1MB block
// - Small pages map 4KB with separate 1KB subpage access bits
// - Large pages map 64KB in one entry, 16KB subpage access bits
// - Domain register holds sixteen two-bit access fields
// - Cache holds 64 translations used on most accesses
// - Hit checks permission; allowed gives physical address, else abort
// - Miss walks the table in memory then stores the result
// - Victim entry chosen round robin
// - Cache operation write invalidates one matching entry or all
// - Fault status holds domain in 7..4, type in 3..0
// - Fault address holds the attempted virtual address
// - Fault records change only for data faults and register writes, not prefetch
// - First fetch address is base 31..14 with VA 31..20
// - First descriptor 00 faults, 01 page table, 10 section, 11 reserved
// - Walk starts at level one; pages need a level-two fetch
// - Page table descriptor bits 8..5 give the domain
// - Page table descriptor bits 31..10 give second table base
// - Second descriptor 00 faults, 01 large, 10 small, 11 reserved
// - Section descriptor bits 31..20 give physical upper bits
// - Control bit 0 enables translation
module vatu_top
   import vatu_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic VA_REQ,
   input wire logic [31:0] VA,
   input wire logic VA_WRITE,
   input wire logic VA_DATA,
   input wire logic VA_PRIV,
   output logic DONE,
   output logic ABORT,
   output logic [31:0] PA,
   output logic WALK_REQ,
   output logic [31:0] WALK_ADDR,
   input wire logic WALK_ACK,
   input wire logic [31:0] WALK_RDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [3:0] REG_SEL,
   input wire logic REG_OP_ONE,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA
);
   vatu_tlb_if t ();
   vatu_state_t state_q, state_d;
   logic [31:0] ctrl_q, tbase_q, dac_q, fstat_q, fva_q;
   logic [31:0] va_q, walk_addr_q, pa_q, rdata_q, rdata_d;
   logic wr_q, data_q, priv_q, done_q, abort_q;
   vatu_size_t fsz_q;
   logic [19:0] fpb_q;
   logic [3:0] fdom_q;
   logic [7:0] fap_q;

   // Same-cycle permission rules for the client domain
   function automatic logic perm_ok(input logic [1:0] ap,
      input logic s, input logic r, input logic priv, input logic wr);
      case (ap)
         2'h0: perm_ok = !wr && ((s && !r && priv) || (!s && r));
         2'h1: perm_ok = priv;
         2'h2: perm_ok = priv || !wr;
         default: perm_ok = 1'b1;
      endcase
   endfunction

   // Register selector decode, shared by the write and read paths
   function automatic logic sel_is(input logic [3:0] sel,
      input logic [3:0] num);
      sel_is = sel == num;
   endfunction

   // ----------------------------------------------------------------
   // Register port decode
   // ----------------------------------------------------------------
   wire wr_ctrl = REG_WR && sel_is(REG_SEL, REG_CTRL);
   wire wr_tbase = REG_WR && sel_is(REG_SEL, REG_TBASE);
   wire wr_dac = REG_WR && sel_is(REG_SEL, REG_DAC);
   wire wr_fstat = REG_WR && sel_is(REG_SEL, REG_FSTAT);
   wire wr_fva = REG_WR && sel_is(REG_SEL, REG_FVA);
   wire wr_op = REG_WR && sel_is(REG_SEL, REG_TLBOP);
   wire en = ctrl_q[CTL_EN];

   // Read mux; unselected and write-only numbers read zero
   always_comb begin
      if (sel_is(REG_SEL, REG_CTRL)) begin
         rdata_d = ctrl_q;
      end else if (sel_is(REG_SEL, REG_TBASE)) begin
         rdata_d = tbase_q;
      end else if (sel_is(REG_SEL, REG_DAC)) begin
         rdata_d = dac_q;
      end else if (sel_is(REG_SEL, REG_FSTAT)) begin
         rdata_d = fstat_q;
      end else if (sel_is(REG_SEL, REG_FVA)) begin
         rdata_d = fva_q;
      end else begin
         rdata_d = 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Hit checking
   // ----------------------------------------------------------------
   wire [1:0] dom_bits = dac_q[{t.hit_dom, 1'b0} +: 2];
   wire is_sect = t.hit_size == VATU_SZ_SECT;
   wire dom_fault = dom_bits == DA_NONE || dom_bits == DA_RSVD;
   wire perm_fault = dom_bits == DA_CLIENT && !perm_ok(t.hit_ap,
      ctrl_q[CTL_S], ctrl_q[CTL_R], priv_q, wr_q);
   wire look = state_q == ST_LOOK;
   wire hit_ok = look && t.hit && !dom_fault && !perm_fault;
   wire hit_bad = look && t.hit && (dom_fault || perm_fault);
   wire [3:0] hit_fs = dom_fault ?
      (is_sect ? FS_DOM_SECT : FS_DOM_PAGE) :
      (is_sect ? FS_PERM_SECT : FS_PERM_PAGE);

   // ----------------------------------------------------------------
   // Walk decode
   // ----------------------------------------------------------------
   wire [1:0] dtype = WALK_RDATA[1:0];
   wire l1_ack = state_q == ST_L1 && WALK_ACK;
   wire l2_ack = state_q == ST_L2 && WALK_ACK;
   wire l1_bad = l1_ack && (dtype == L1_INVALID ||
      dtype == 2'h3);
   wire l2_bad = l2_ack && (dtype == L2_INVALID ||
      dtype == 2'h3);
   wire fault_ev = hit_bad || l1_bad || l2_bad;
   wire [3:0] fault_fs = hit_bad ? hit_fs :
      l1_bad ? FS_TRANS_SECT : FS_TRANS_PAGE;
   wire [3:0] fault_dom = hit_bad ? t.hit_dom :
      l1_bad ? 4'h0 : fdom_q;
   wire [31:0] l1_addr = {tbase_q[31:14], va_q[31:20], 2'b00};
   wire [31:0] l2_addr = {WALK_RDATA[31:10], va_q[19:12],
      2'b00};

   // Next state; every walk enters at level one
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (VA_REQ && en) begin
               state_d = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (t.hit) begin
               state_d = ST_IDLE;
            end else begin
               state_d = ST_L1;
            end
         end
         ST_L1: begin
            if (l1_bad) begin
               state_d = ST_IDLE;
            end else if (l1_ack && dtype == L1_SECT) begin
               state_d = ST_FILL;
            end else if (l1_ack) begin
               state_d = ST_L2;
            end
         end
         ST_L2: begin
            if (l2_bad) begin
               state_d = ST_IDLE;
            end else if (l2_ack) begin
               state_d = ST_FILL;
            end
         end
         default: state_d = ST_LOOK;
      endcase
   end

   // Cache connections; fill result is looked up again next cycle
   assign t.lk_va = va_q;
   assign t.fill = state_q == ST_FILL;
   assign t.fill_tag = va_q[31:12];
   assign t.fill_size = fsz_q;
   assign t.fill_pbase = fpb_q;
   assign t.fill_dom = fdom_q;
   assign t.fill_ap = fap_q;
   assign t.inv_all = wr_op && !REG_OP_ONE;
   assign t.inv_one = wr_op && REG_OP_ONE;
   assign t.inv_va = REG_WDATA;

   vatu_tlb vatu_tlb_inst (
      .clk(CLK),
      .rst_n(RST_N),
      .t(t.tlb)
   );

   // ----------------------------------------------------------------
   // Sequential logic
   // ----------------------------------------------------------------
   // State and access latch; the access is held for the whole walk
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         va_q <= 32'h0000_0000;
         wr_q <= 1'b0;
         data_q <= 1'b0;
         priv_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (state_q == ST_IDLE && VA_REQ) begin
            va_q <= VA;
            wr_q <= VA_WRITE;
            data_q <= VA_DATA;
            priv_q <= VA_PRIV;
         end
      end
   end

   // Answer to the core: pass-through, hit, or abort
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         done_q <= 1'b0;
         abort_q <= 1'b0;
         pa_q <= 32'h0000_0000;
      end else begin
         done_q <= (state_q == ST_IDLE && VA_REQ && !en) ||
            look && t.hit || l1_bad || l2_bad;
         abort_q <= fault_ev;
         if (state_q == ST_IDLE && VA_REQ && !en) begin
            pa_q <= VA;
         end else if (hit_ok) begin
            pa_q <= t.hit_pa;
         end
      end
   end

   // Walk address and descriptor capture for the coming fill
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         walk_addr_q <= 32'h0000_0000;
         fsz_q <= VATU_SZ_SMALL;
         fpb_q <= 20'h00000;
         fdom_q <= 4'h0;
         fap_q <= 8'h00;
      end else if (look && !t.hit) begin
         walk_addr_q <= l1_addr;
      end else if (l1_ack && dtype == L1_SECT) begin
         fsz_q <= VATU_SZ_SECT;
         fpb_q <= {WALK_RDATA[31:20], 8'h00};
         fdom_q <= WALK_RDATA[8:5];
         fap_q <= {4{WALK_RDATA[11:10]}};
      end else if (l1_ack && dtype == L1_PAGE) begin
         walk_addr_q <= l2_addr;
         fdom_q <= WALK_RDATA[8:5];
      end else if (l2_ack && !l2_bad) begin
         fsz_q <= dtype == L2_LARGE ? VATU_SZ_LARGE : VATU_SZ_SMALL;
         fpb_q <= dtype == L2_LARGE ? {WALK_RDATA[31:16], 4'h0} :
            WALK_RDATA[31:12];
         fap_q <= WALK_RDATA[11:4];
      end
   end

   // Control registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctrl_q <= CTRL_RST;
         tbase_q <= TBASE_RST;
         dac_q <= DAC_RST;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) ctrl_q <= REG_WDATA;
         if (wr_tbase) tbase_q <= REG_WDATA;
         if (wr_dac) dac_q <= REG_WDATA;
         if (REG_RD) rdata_q <= rdata_d;
      end
   end

   // Fault records; a data fault wins over a software write
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         fstat_q <= FSTAT_RST;
         fva_q <= FVA_RST;
      end else if (fault_ev && data_q) begin
         fstat_q <= {24'h000000, fault_dom, fault_fs};
         fva_q <= va_q;
      end else begin
         if (wr_fstat) fstat_q <= REG_WDATA;
         if (wr_fva) fva_q <= REG_WDATA;
      end
   end

   assign DONE = done_q;
   assign ABORT = abort_q;
   assign PA = pa_q;
   assign WALK_REQ = state_q == ST_L1 || state_q == ST_L2;
   assign WALK_ADDR = walk_addr_q;
   assign REG_RDATA = rdata_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   chk_pass_through: assert property (state_q == ST_IDLE &&
      VA_REQ && !en |=> DONE && !ABORT && PA == $past(VA))
      else $error("pass-through address wrong");
   chk_hit_answer: assert property (hit_ok |=>
      DONE && !ABORT && PA == $past(t.hit_pa))
      else $error("allowed hit not answered");
   chk_l1_addr: assert property (state_q == ST_L1 |->
      WALK_ADDR == {tbase_q[31:14], va_q[31:20], 2'b00})
      else $error("level one fetch address wrong");
   chk_l1_reserved: assert property (l1_ack && dtype == 2'h3
      |=> ABORT && DONE && !WALK_REQ ##1 !WALK_REQ)
      else $error("reserved descriptor not faulted");
   chk_l2_addr: assert property (l1_ack && dtype == L1_PAGE
      |=> state_q == ST_L2 && WALK_ADDR[31:10] ==
      $past(WALK_RDATA[31:10])) else $error("second table base wrong");
   chk_sect_fill: assert property (l1_ack && dtype == L1_SECT
      |=> t.fill ##1 look) else $error("section fill skipped");
   chk_fault_rec: assert property (fault_ev && data_q |=>
      fstat_q[7:0] == {$past(fault_dom), $past(fault_fs)} &&
      fva_q == $past(va_q)) else $error("fault record wrong");
   chk_prefetch_hold: assert property (fault_ev && !data_q &&
      !wr_fstat && !wr_fva |=> $stable(fstat_q) && $stable(fva_q))
      else $error("prefetch fault changed records");
   cov_sect_walk: cover property (l1_ack && dtype == L1_SECT);
   cov_page_walk: cover property (l2_ack && dtype == L2_SMALL);
   cov_hit_ok: cover property (hit_ok);
   cov_abort: cover property (hit_bad ##1 ABORT);
endmodule
`default_nettype wire

// *** tb/tb_vatu.sv ***
// Purpose: Self-checking bench for the address translation unit
// Assumes: Memory model answers walks; inputs move on falling edges
// Notes:   Round-robin victim order is left to the design's assertions
`timescale 1ns/1ns
`default_nettype none
module tb_vatu;
   import vatu_pkg::*;
   logic CLK = 1'b0, RST_N = 1'b0, VA_REQ = 1'b0, VA_WRITE = 1'b0;
   logic VA_DATA = 1'b1, VA_PRIV = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
   logic REG_OP_ONE = 1'b0, DONE, ABORT, WALK_REQ, WALK_ACK, ab;
   logic [3:0] REG_SEL = 4'h0, lat = 4'h3;
   logic [31:0] VA = 32'h0, REG_WDATA = 32'h0, PA, WALK_ADDR, WALK_RDATA;
   logic [31:0] REG_RDATA, rd, first_addr;
   int n_mismatch = 0, check_count = 0, fetches = 0, cyc = 0;
   vatu_top vatu_top_inst (.CLK(CLK), .RST_N(RST_N), .VA_REQ(VA_REQ),
      .VA(VA), .VA_WRITE(VA_WRITE), .VA_DATA(VA_DATA), .VA_PRIV(VA_PRIV),
      .DONE(DONE), .ABORT(ABORT), .PA(PA), .WALK_REQ(WALK_REQ),
      .WALK_ADDR(WALK_ADDR), .WALK_ACK(WALK_ACK), .WALK_RDATA(WALK_RDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_SEL(REG_SEL),
      .REG_OP_ONE(REG_OP_ONE), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA));
   vatu_mem_model vatu_mem_model_inst (.clk(CLK), .lat(lat),
      .walk_req(WALK_REQ), .walk_addr(WALK_ADDR), .walk_ack(WALK_ACK),
      .walk_rdata(WALK_RDATA));
   // ----------------------------------------------------------------
   // Clock, fetch monitor and helper tasks
   // ----------------------------------------------------------------
   initial begin
      forever #50 CLK = ~CLK;
   end
   // Counting taken fetches proves whether a lookup hit or walked
   always @(posedge CLK) begin
      if (WALK_REQ && WALK_ACK) begin
         if (fetches == 0) first_addr <= WALK_ADDR;
         fetches <= fetches + 1;
      end
   end
   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic reg_op(input logic wr, input logic [3:0] sel,
      input logic [31:0] d, input logic one);
      @(negedge CLK);
      REG_WR = wr;
      REG_RD = !wr;
      REG_SEL = sel;
      REG_WDATA = d;
      REG_OP_ONE = one;
      @(negedge CLK);
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      rd = REG_RDATA;
   endtask
   // Bounded wait so a lost answer cannot hang the run
   task automatic access(input logic [31:0] va, input logic data);
      @(negedge CLK);
      VA_REQ = 1'b1;
      VA = va;
      VA_DATA = data;
      fetches = 0;
      cyc = 0;
      do begin
         @(negedge CLK);
         VA_REQ = 1'b0;
         cyc++;
      end while (DONE !== 1'b1 && cyc < 300);
      ab = ABORT;
      if (cyc >= 300) n_mismatch++;
   endtask
   task automatic xlate(input logic [31:0] va, input logic [31:0] pa,
      input int nf);
      access(va, 1'b1);
      check("abort", {31'h0, ab}, 32'h0);
      check("pa", PA, pa);
      check("fetches", 32'(fetches), 32'(nf));
   endtask
   task automatic fault(input logic [31:0] va, input logic data,
      input logic [31:0] fstat, input logic [31:0] fva);
      access(va, data);
      check("abort", {31'h0, ab}, 32'h1);
      reg_op(1'b0, REG_FSTAT, 32'h0, 1'b0);
      check("fault status", rd, fstat);
      reg_op(1'b0, REG_FVA, 32'h0, 1'b0);
      check("fault address", rd, fva);
   endtask
   task automatic t_reset_pass();
      logic [3:0] sels [6] = '{REG_CTRL, REG_TBASE, REG_DAC, REG_FSTAT,
         REG_FVA, 4'h4};
      foreach (sels[i]) begin
         reg_op(1'b0, sels[i], 32'h0, 1'b0);
         check("reset reg", rd, 32'h0);
      end
      xlate(32'h1234_5678, 32'h1234_5678, 0);
      check("off latency", 32'(cyc), 32'h1);
   endtask
   task automatic t_section();
      reg_op(1'b1, REG_TBASE, 32'h0001_0000, 1'b0);
      reg_op(1'b1, REG_DAC, 32'h0000_0005, 1'b0);
      reg_op(1'b1, REG_CTRL, 32'h0000_0001, 1'b0);
      reg_op(1'b0, REG_DAC, 32'h0, 1'b0);
      check("domains", rd, 32'h0000_0005);
      vatu_mem_model_inst.poke(32'h0001_0010, 32'h1230_0C12);
      xlate(32'h0040_5678, 32'h1230_5678, 1);
      check("l1 addr", first_addr, 32'h0001_0010);
      xlate(32'h004F_FFFC, 32'h123F_FFFC, 0);
      check("hit latency", 32'(cyc), 32'h2);
   endtask
   task automatic t_page();
      vatu_mem_model_inst.poke(32'h0001_0014, 32'h0002_0411);
      vatu_mem_model_inst.poke(32'h0002_040C, 32'hABCD_EFF2);
      vatu_mem_model_inst.poke(32'h0001_0018, 32'h0002_0811);
      vatu_mem_model_inst.poke(32'h0002_0814, 32'h7777_0FF1);
      xlate(32'h0050_3ABC, 32'hABCD_EABC, 2);
      xlate(32'h0060_5123, 32'h7777_5123, 2);
      xlate(32'h0060_F000, 32'h7777_F000, 0);
   endtask
   task automatic t_fault();
      lat = 4'h0;
      fault(32'h0070_0004, 1'b1, 32'h05, 32'h0070_0004);
      vatu_mem_model_inst.poke(32'h0001_0020, 32'h0000_0003);
      fault(32'h0080_0000, 1'b1, 32'h05, 32'h0080_0000);
      check("fetches", 32'(fetches), 32'h1);
      fault(32'h0090_0000, 1'b0, 32'h05, 32'h0080_0000);
      vatu_mem_model_inst.poke(32'h0001_0028, 32'h00A0_0C52);
      fault(32'h00A0_0000, 1'b1, 32'h29, 32'h00A0_0000);
      vatu_mem_model_inst.poke(32'h0001_002C, 32'h0002_0C31);
      fault(32'h00B0_0000, 1'b1, 32'h17, 32'h00B0_0000);
      // Supervisor-only section: user read faults, supervisor write passes
      vatu_mem_model_inst.poke(32'h0001_0030, 32'h00C0_0412);
      VA_PRIV = 1'b0;
      fault(32'h00C0_0000, 1'b1, 32'h0D, 32'h00C0_0000);
      VA_PRIV = 1'b1;
      VA_WRITE = 1'b1;
      xlate(32'h00C0_0010, 32'h00C0_0010, 0);
      VA_WRITE = 1'b0;
   endtask
   // Flush after any table change, as software must
   task automatic t_inval();
      reg_op(1'b1, REG_TLBOP, 32'h0040_5678, 1'b1);
      xlate(32'h0040_5678, 32'h1230_5678, 1);
      xlate(32'h0050_3ABC, 32'hABCD_EABC, 0);
      reg_op(1'b1, REG_TLBOP, 32'h0, 1'b0);
      xlate(32'h0060_5123, 32'h7777_5123, 2);
   endtask
   initial begin
      repeat (16) @(negedge CLK);
      RST_N = 1'b1;
      t_reset_pass();
      t_section();
      t_page();
      t_fault();
      t_inval();
      finish_test();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge CLK);
      n_mismatch++;
      finish_test();
   end
endmodule
`default_nettype wire

// *** tb/vatu_mem_model.sv ***
// Purpose: Table memory answering descriptor fetches
// Assumes: One word per fetch, answered after lat waiting cycles
// Notes:   Idle data toggles so a stale word is never mistaken
`timescale 1ns/1ns
`default_nettype none
module vatu_mem_model (
   input wire logic clk,
   input wire logic [3:0] lat,
   input wire logic walk_req,
   input wire logic [31:0] walk_addr,
   output logic walk_ack,
   output logic [31:0] walk_rdata
);
   logic [31:0] mem [logic [31:0]];
   int cnt = 0;
   initial begin
      walk_ack = 1'b0;
      walk_rdata = 32'h0;
   end
   // Bench places level-one and level-two tables, some with faulting or reserved descriptors
   task automatic poke(input logic [31:0] a, input logic [31:0] d);
      mem[a] = d;
   endtask
   // Falling-edge answer; acknowledge lasts exactly one cycle
   always @(negedge clk) begin
      walk_rdata <= ~walk_rdata;
      if (walk_ack || !walk_req) begin
         walk_ack <= 1'b0;
         cnt <= 0;
      end else if (cnt >= lat) begin
         walk_ack <= 1'b1;
         walk_rdata <= mem.exists(walk_addr) ? mem[walk_addr] : 32'h0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire
